// file: rsdc_consts.svh
`ifndef RSDC_CONSTS_SVH
`define RSDC_CONSTS_SVH
// ----------------------------------------------------------------
// clock and timing
// ----------------------------------------------------------------
`define RSDC_CLK_NS        8
`define RSDC_DT_LIMIT_NS   1000
`define RSDC_TON_MAX_NS    25000
`define RSDC_OFFTIME_NS    20000
`define RSDC_QUIET_NS      125000
`define RSDC_AREC_NS       1000000
`define RSDC_ON_W          12
// ----------------------------------------------------------------
// register word offsets
// ----------------------------------------------------------------
`define RSDC_ADDR_CTRL     6'h00
`define RSDC_ADDR_SSCFG    6'h01
`define RSDC_ADDR_TIMCFG   6'h02
`define RSDC_ADDR_QUIET    6'h03
`define RSDC_ADDR_MAXON    6'h04
`define RSDC_ADDR_STATUS   6'h05
`define RSDC_ADDR_SSVAL    6'h06
// ----------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------
`define RSDC_CTRL_EN       0
`define RSDC_CTRL_DTM      2:1
`define RSDC_CTRL_FIXDT    3
`define RSDC_CTRL_FCNT     4
`define RSDC_CTRL_FCLR     5
`define RSDC_ST_TMAX       5
`define RSDC_ST_DTF        6
`define RSDC_CTRL_RST      32'h0000_0000
`define RSDC_SSCFG_RST     32'h0000_0110
`define RSDC_FCNT_RST      4'h4
`endif

// file: rsdc_pkg.sv
`default_nettype none
`include "rsdc_consts.svh"
package rsdc_pkg;
  // ----------------------------------------------------------------
  // sequencer states and options
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_OFF   = 4'h0, ST_DISCH = 4'h1, ST_WAIT  = 4'h2, ST_UPPER = 4'h3,
    ST_DT1   = 4'h4, ST_LOWER = 4'h5, ST_DT2   = 4'h6, ST_OFFT  = 4'h7,
    ST_SKIP  = 4'h8, ST_THERM = 4'h9, ST_LATCH = 4'ha, ST_RECOV = 4'hb
  } rsdc_state_e;
  typedef enum logic [1:0] {
    DTF_FORCE = 2'h0, DTF_LATCH = 2'h1, DTF_RECOV = 2'h2, DTF_RSVD = 2'h3
  } rsdc_dtf_e;
  typedef logic [`RSDC_ON_W-1:0] rsdc_on_t;
  typedef struct packed {
    rsdc_state_e fsm;
    rsdc_on_t    on_cnt;
    logic        dir_down;
    logic        repeat_en;
    logic        regulated;
    logic        tmax_flt;
    logic        dt_flt;
    logic        therm_mem;
    logic        drv_up;
    logic        drv_lo;
    logic        dis;
    logic [23:0] tmr;
    logic [31:0] ctrl;
    logic [31:0] sscfg;
    logic [31:0] timcfg;
    logic [31:0] quiet;
    logic [31:0] maxon;
    logic        ack;
    logic [31:0] rdat;
  } rsdc_top_s;
endpackage
`default_nettype wire

// file: rsdc_dt_if.sv
`timescale 1ns/100ps
`default_nettype none
// dead-time request and answer between sequencer and timer
interface rsdc_dt_if;
  logic       start;
  logic       sense_end;
  logic       fixed;
  logic [7:0] limit;
  logic       cnt_en;
  logic [3:0] fault_n;
  logic       done;
  logic       fault;
  modport ctl (output start, sense_end, fixed, limit, cnt_en, fault_n, input done, fault);
  modport dt  (input start, sense_end, fixed, limit, cnt_en, fault_n, output done, fault);
endinterface
`default_nettype wire

// file: rsdc_softstart.sv
`timescale 1ns/100ps
`default_nettype none
module rsdc_softstart #(
  parameter int unsigned W = 12
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic         ce_i,
  input  wire logic         load_i,
  input  wire logic [W-1:0] load_val_i,
  input  wire logic         sat_i,
  input  wire logic         tick_i,
  input  wire logic [W-1:0] max_i,
  input  wire logic [7:0]   inc_i,
  input  wire logic [7:0]   div_i,
  output logic      [W-1:0] cnt_o
);
  import rsdc_pkg::*;
  if (W < 8 || W > 16) begin : g_chk
    $error("softstart width out of range");
  end
  typedef struct packed {
    logic [W-1:0] cnt;
    logic [7:0]   div_cnt;
  } rsdc_ss_s;
  rsdc_ss_s ss_reg;
  rsdc_ss_s ss_next;
  logic [W:0] sum;
  // ----------------------------------------------------------------
  // counter: load, saturate, divided increment
  // ----------------------------------------------------------------
  always_comb begin
    ss_next = ss_reg;
    sum     = {1'b0, ss_reg.cnt} + {{(W-7){1'b0}}, inc_i};
    if (load_i) begin
      ss_next.cnt     = (load_val_i > max_i) ? max_i : load_val_i;
      ss_next.div_cnt = 8'h00;
    end else if (sat_i) begin
      ss_next.cnt = max_i;
    end else if (tick_i) begin
      if (ss_reg.div_cnt + 8'h01 >= div_i) begin
        ss_next.div_cnt = 8'h00;
        ss_next.cnt     = (sum > {1'b0, max_i}) ? max_i : sum[W-1:0];
      end else begin
        ss_next.div_cnt = ss_reg.div_cnt + 8'h01;
      end
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ss_reg <= '0;
    end else if (ce_i) begin
      ss_reg <= ss_next;
    end
  end
  assign cnt_o = ss_reg.cnt;
  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  ss_load_a: assert property (@(posedge clk_i) disable iff (rst_i || !ce_i)
    load_i && load_val_i <= max_i |=> cnt_o == $past(load_val_i))
    else $error("soft-start preload lost");
  ss_sat_a: assert property (@(posedge clk_i) disable iff (rst_i || !ce_i)
    sat_i && !load_i |=> cnt_o == $past(max_i))
    else $error("soft-start not saturated");
endmodule
`default_nettype wire

// file: rsdc_deadtime.sv
`timescale 1ns/100ps
`default_nettype none
module rsdc_deadtime (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic ce_i,
  rsdc_dt_if.dt     dt
);
  import rsdc_pkg::*;
  typedef struct packed {
    logic       active;
    logic [7:0] tmr;
    logic [3:0] fcnt;
    logic       done;
    logic       fault;
  } rsdc_dt_s;
  rsdc_dt_s dt_reg;
  rsdc_dt_s dt_next;
  // ----------------------------------------------------------------
  // adaptive gap with limit clamp and fault counting
  // ----------------------------------------------------------------
  always_comb begin
    dt_next       = dt_reg;
    dt_next.done  = 1'b0;
    dt_next.fault = 1'b0;
    if (dt.start) begin
      dt_next.active = 1'b1;
      dt_next.tmr    = 8'h01;
    end else if (dt_reg.active) begin
      if (!dt.fixed && dt.sense_end) begin
        dt_next.active = 1'b0;
        dt_next.done   = 1'b1;
      end else if (dt_reg.tmr >= dt.limit) begin
        dt_next.active = 1'b0;
        dt_next.done   = 1'b1;
        if (!dt.fixed) begin
          if (!dt.cnt_en || dt_reg.fcnt + 4'h1 >= dt.fault_n) begin
            dt_next.fault = 1'b1;
            dt_next.fcnt  = 4'h0;
          end else begin
            dt_next.fcnt = dt_reg.fcnt + 4'h1;
          end
        end
      end else begin
        dt_next.tmr = dt_reg.tmr + 8'h01;
      end
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dt_reg <= '0;
    end else if (ce_i) begin
      dt_reg <= dt_next;
    end
  end
  assign dt.done  = dt_reg.done;
  assign dt.fault = dt_reg.fault;
  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  dt_fixed_hold_a: assert property (@(posedge clk_i) disable iff (rst_i || !ce_i)
    dt_reg.active && dt.fixed && !dt.start && dt_reg.tmr < dt.limit |=> !dt_reg.done && dt_reg.active)
    else $error("fixed gap ended early");
  dt_fault_gate_a: assert property (@(posedge clk_i) disable iff (rst_i || !ce_i)
    dt_reg.fault |-> !$past(dt.fixed))
    else $error("gap fault with fixed gap");
endmodule
`default_nettype wire

// file: rsdc_top.sv
// Overview of operation
// - preload soft-start with final startup on-time
// - upper driven while on-time counts up
// - soft-start count match turns count downward
// - gap, then lower until count reaches zero
// - each lower pulse advances soft-start divider
// - increment on every N-th lower pulse
// - soft-start count drives comparator reference DAC
// - comparator ends on-time once regulating
// - soft-start keeps counting until saturated
// - max on-time fault only at limit
// - repetition disabled when soft-start begins
// - repetition enabled when comparator trips early
// - symmetric halves, off-time gaps at light load
// - quiet skip bursts clamped to set frequency
// - opposite switch on at transition end
// - force opposite switch when gap limit expires
// - gap expiry: force, latch, or recover
// - fault confirmed after set expiry count
// - fixed gap ignores sense, no fault
// - discharge bridge node to floor first
// - over-temperature stops, remembers, then full restart
// - skip entry level saturates soft-start
`timescale 1ns/100ps
`default_nettype none
module rsdc_top #(
  parameter logic [15:0] QUIET_CYCLES = 16'(`RSDC_QUIET_NS / `RSDC_CLK_NS),
  parameter int unsigned AREC_CYCLES  = `RSDC_AREC_NS / `RSDC_CLK_NS
) (
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic              ce_i,
  input  wire logic [7:0]        wb_adr_i,
  input  wire logic [31:0]       wb_dat_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic              wb_we_i,
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  output logic      [31:0]       wb_dat_o,
  output logic                   wb_ack_o,
  input  wire logic              startup_done_i,
  input  wire rsdc_pkg::rsdc_on_t startup_ontime_i,
  input  wire logic              ontime_cmp_i,
  input  wire logic              fb_below_skip_i,
  input  wire logic              light_load_i,
  input  wire logic              fb_below_quiet_i,
  input  wire logic              trans_end_up2lo_i,
  input  wire logic              trans_end_lo2up_i,
  input  wire logic              bridge_floor_i,
  input  wire logic              over_temp_i,
  input  wire logic              temp_low_i,
  output logic                   drv_upper_o,
  output logic                   drv_lower_o,
  output logic                   bridge_discharge_o,
  output rsdc_pkg::rsdc_on_t     dac_o,
  output logic                   repeat_en_o,
  output logic                   fault_latched_o
);
  import rsdc_pkg::*;
  if (AREC_CYCLES < 1 || AREC_CYCLES > 24'hffffff) begin : g_chk
    $error("recovery count does not fit timer");
  end
  localparam logic [23:0] AREC_C   = 24'(AREC_CYCLES);
  localparam logic [7:0]  DT_LIM_C = 8'(`RSDC_DT_LIMIT_NS / `RSDC_CLK_NS);
  localparam logic [11:0] TMAX_C   = 12'(`RSDC_TON_MAX_NS / `RSDC_CLK_NS);
  localparam logic [15:0] OFFT_C   = 16'(`RSDC_OFFTIME_NS / `RSDC_CLK_NS);

  rsdc_top_s r_reg;
  rsdc_top_s r_next;
  rsdc_on_t  ss_cnt;
  logic      ss_load;
  logic      ss_tick;
  logic      ss_sat;
  logic      dt_go;
  logic      acc;
  logic      wr;
  logic      fclr;
  logic      tmax_set;
  logic      dtf_set;
  logic      end_up;
  logic [31:0] rd;
  rsdc_dtf_e dtm;
  rsdc_dt_if dti ();

  // ----------------------------------------------------------------
  // byte-lane merge for bus writes
  // ----------------------------------------------------------------
  function automatic logic [31:0] wmerge(input logic [31:0] o, input logic [31:0] d, input logic [3:0] s);
    logic [31:0] m;
    m = o;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) begin
        m[i*8 +: 8] = d[i*8 +: 8];
      end
    end
    return m;
  endfunction

  // ----------------------------------------------------------------
  // dead-time timer and soft-start counter
  // ----------------------------------------------------------------
  assign dti.start     = dt_go;
  assign dti.sense_end = (r_reg.fsm == ST_DT1) ? trans_end_up2lo_i : trans_end_lo2up_i;
  assign dti.fixed     = r_reg.ctrl[`RSDC_CTRL_FIXDT];
  assign dti.limit     = r_reg.timcfg[7:0];
  assign dti.cnt_en    = r_reg.ctrl[`RSDC_CTRL_FCNT];
  assign dti.fault_n   = r_reg.timcfg[11:8];

  rsdc_deadtime u_dt (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .ce_i  (ce_i),
    .dt    (dti)
  );

  rsdc_softstart #(.W(`RSDC_ON_W)) u_ss (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .ce_i       (ce_i),
    .load_i     (ss_load),
    .load_val_i (startup_ontime_i),
    .sat_i      (ss_sat),
    .tick_i     (ss_tick),
    .max_i      (r_reg.maxon[11:0]),
    .inc_i      (r_reg.sscfg[7:0]),
    .div_i      (r_reg.sscfg[15:8]),
    .cnt_o      (ss_cnt)
  );

  // ----------------------------------------------------------------
  // register read mux
  // ----------------------------------------------------------------
  always_comb begin
    unique case (wb_adr_i[7:2])
      `RSDC_ADDR_CTRL:   rd = r_reg.ctrl;
      `RSDC_ADDR_SSCFG:  rd = r_reg.sscfg;
      `RSDC_ADDR_TIMCFG: rd = r_reg.timcfg;
      `RSDC_ADDR_QUIET:  rd = r_reg.quiet;
      `RSDC_ADDR_MAXON:  rd = r_reg.maxon;
      `RSDC_ADDR_STATUS: rd = {21'h0, r_reg.regulated, r_reg.drv_lo, r_reg.drv_up, r_reg.therm_mem,
                               r_reg.dt_flt, r_reg.tmax_flt, r_reg.repeat_en, r_reg.fsm};
      `RSDC_ADDR_SSVAL:  rd = {20'h0, ss_cnt};
      default:           rd = 32'h0000_0000;
    endcase
  end

  // ----------------------------------------------------------------
  // bus slave, sequencer and fault flags
  // ----------------------------------------------------------------
  always_comb begin
    r_next   = r_reg;
    ss_load  = 1'b0;
    ss_tick  = 1'b0;
    dt_go    = 1'b0;
    tmax_set = 1'b0;
    dtf_set  = 1'b0;
    end_up   = 1'b0;
    dtm      = rsdc_dtf_e'(r_reg.ctrl[`RSDC_CTRL_DTM]);
    acc      = wb_cyc_i && wb_stb_i && !r_reg.ack;
    wr       = acc && wb_we_i;
    fclr     = 1'b0;
    r_next.ack = acc;
    if (acc && !wb_we_i) begin
      r_next.rdat = rd;
    end
    if (wr) begin
      unique case (wb_adr_i[7:2])
        `RSDC_ADDR_CTRL: begin
          r_next.ctrl = wmerge(r_reg.ctrl, wb_dat_i, wb_sel_i) & 32'h0000_001f;
          fclr        = wb_sel_i[0] && wb_dat_i[`RSDC_CTRL_FCLR];
        end
        `RSDC_ADDR_SSCFG:  r_next.sscfg  = wmerge(r_reg.sscfg, wb_dat_i, wb_sel_i) & 32'h0000_ffff;
        `RSDC_ADDR_TIMCFG: r_next.timcfg = wmerge(r_reg.timcfg, wb_dat_i, wb_sel_i) & 32'hffff_0fff;
        `RSDC_ADDR_QUIET:  r_next.quiet  = wmerge(r_reg.quiet, wb_dat_i, wb_sel_i) & 32'h0000_ffff;
        `RSDC_ADDR_MAXON:  r_next.maxon  = wmerge(r_reg.maxon, wb_dat_i, wb_sel_i) & 32'h0000_0fff;
        `RSDC_ADDR_STATUS: begin
          if (wb_sel_i[0] && wb_dat_i[`RSDC_ST_TMAX]) r_next.tmax_flt = 1'b0;
          if (wb_sel_i[0] && wb_dat_i[`RSDC_ST_DTF])  r_next.dt_flt   = 1'b0;
        end
        default: ;
      endcase
    end
    // switching sequence
    unique case (r_reg.fsm)
      ST_OFF: begin
        if (r_reg.ctrl[`RSDC_CTRL_EN]) begin
          r_next.fsm = ST_DISCH;
        end
      end
      ST_DISCH: begin
        if (bridge_floor_i) begin
          r_next.fsm = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (startup_done_i) begin
          ss_load          = 1'b1;
          r_next.repeat_en = 1'b0;
          r_next.regulated = 1'b0;
          r_next.on_cnt    = '0;
          r_next.fsm       = ST_UPPER;
        end
      end
      ST_UPPER: begin
        r_next.on_cnt = r_reg.on_cnt + 12'h001;
        if (!ontime_cmp_i) begin
          end_up           = 1'b1;
          r_next.repeat_en = 1'b1;
          r_next.regulated = 1'b1;
        end else if (r_reg.on_cnt + 12'h001 >= ss_cnt) begin
          end_up = 1'b1;
        end
        if (ss_cnt == r_reg.maxon[11:0] && r_reg.on_cnt + 12'h001 >= r_reg.maxon[11:0]) begin
          tmax_set = 1'b1;
        end
        if (end_up) begin
          r_next.dir_down = 1'b1;
          dt_go           = 1'b1;
          r_next.fsm      = ST_DT1;
        end
      end
      ST_DT1, ST_DT2: begin
        if (dti.fault) begin
          dtf_set = 1'b1;
        end
        if (dti.fault && dtm == DTF_LATCH) begin
          r_next.fsm = ST_LATCH;
        end else if (dti.fault && dtm == DTF_RECOV) begin
          r_next.tmr = 24'h0;
          r_next.fsm = ST_RECOV;
        end else if (dti.done && r_reg.fsm == ST_DT1) begin
          ss_tick    = 1'b1;
          r_next.fsm = ST_LOWER;
        end else if (dti.done) begin
          r_next.on_cnt = '0;
          r_next.tmr    = 24'h0;
          if (fb_below_quiet_i) begin
            r_next.fsm = ST_SKIP;
          end else if (light_load_i) begin
            r_next.fsm = ST_OFFT;
          end else begin
            r_next.fsm = ST_UPPER;
          end
        end
      end
      ST_LOWER: begin
        if (r_reg.dir_down && r_reg.on_cnt != '0) begin
          r_next.on_cnt = r_reg.on_cnt - 12'h001;
        end
        if (r_reg.on_cnt <= 12'h001) begin
          r_next.dir_down = 1'b0;
          dt_go           = 1'b1;
          r_next.fsm      = ST_DT2;
        end
      end
      ST_OFFT: begin
        r_next.tmr = r_reg.tmr + 24'h1;
        if (r_reg.tmr + 24'h1 >= {8'h0, r_reg.timcfg[31:16]}) begin
          r_next.fsm = ST_UPPER;
        end
      end
      ST_SKIP: begin
        if (r_reg.tmr != 24'hffffff) begin
          r_next.tmr = r_reg.tmr + 24'h1;
        end
        if (r_reg.tmr >= {8'h0, r_reg.quiet[15:0]} && !fb_below_quiet_i) begin
          r_next.fsm = ST_UPPER;
        end
      end
      ST_THERM: begin
        if (temp_low_i && !over_temp_i) begin
          r_next.therm_mem = 1'b0;
          r_next.fsm       = ST_OFF;
        end
      end
      ST_LATCH: begin
        if (fclr) begin
          r_next.fsm = ST_OFF;
        end
      end
      ST_RECOV: begin
        r_next.tmr = r_reg.tmr + 24'h1;
        if (r_reg.tmr + 24'h1 >= AREC_C) begin
          r_next.fsm = ST_OFF;
        end
      end
      default: r_next.fsm = ST_OFF;
    endcase
    if (!r_reg.ctrl[`RSDC_CTRL_EN] && r_reg.fsm != ST_LATCH && r_reg.fsm != ST_THERM) begin
      r_next.fsm = ST_OFF;
    end
    if (over_temp_i) begin
      r_next.fsm       = ST_THERM;
      r_next.therm_mem = 1'b1;
    end
    // set wins over software clear
    if (tmax_set) r_next.tmax_flt = 1'b1;
    if (dtf_set)  r_next.dt_flt   = 1'b1;
    r_next.drv_up = (r_next.fsm == ST_UPPER);
    r_next.drv_lo = (r_next.fsm == ST_LOWER);
    r_next.dis    = (r_next.fsm == ST_DISCH);
  end

  // soft-start ends when feedback sinks below skip entry level
  assign ss_sat = fb_below_skip_i && r_reg.fsm != ST_OFF && r_reg.fsm != ST_DISCH && r_reg.fsm != ST_WAIT;

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      r_reg        <= '0;
      r_reg.fsm    <= ST_OFF;
      r_reg.ctrl   <= `RSDC_CTRL_RST;
      r_reg.sscfg  <= `RSDC_SSCFG_RST;
      r_reg.timcfg <= {OFFT_C, 4'h0, `RSDC_FCNT_RST, DT_LIM_C};
      r_reg.quiet  <= {16'h0, QUIET_CYCLES};
      r_reg.maxon  <= {20'h0, TMAX_C};
    end else if (ce_i) begin
      r_reg <= r_next;
    end
  end

  assign wb_dat_o           = r_reg.rdat;
  assign wb_ack_o           = r_reg.ack;
  assign drv_upper_o        = r_reg.drv_up;
  assign drv_lower_o        = r_reg.drv_lo;
  assign bridge_discharge_o = r_reg.dis;
  assign dac_o              = ss_cnt;
  assign repeat_en_o        = r_reg.repeat_en;
  assign fault_latched_o    = (r_reg.fsm == ST_LATCH);

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence up_end_s;
    drv_upper_o ##1 !drv_upper_o;
  endsequence
  drv_excl_a: assert property (@(posedge clk_i) disable iff (rst_i) !(drv_upper_o && drv_lower_o))
    else $error("both drivers on");
  dead_gap_a: assert property (@(posedge clk_i) disable iff (rst_i || !ce_i) up_end_s |-> !drv_lower_o)
    else $error("no gap after upper");
  therm_stop_a: assert property (@(posedge clk_i) disable iff (rst_i || !ce_i)
    over_temp_i |=> !drv_upper_o && !drv_lower_o && r_reg.therm_mem)
    else $error("switching after over-temperature");
  disch_end_a: assert property (@(posedge clk_i) disable iff (rst_i || !ce_i)
    r_reg.fsm == ST_DISCH && bridge_floor_i && !over_temp_i |=> !bridge_discharge_o)
    else $error("discharge beyond floor");
  rep_off_a: assert property (@(posedge clk_i) disable iff (rst_i || !ce_i)
    r_reg.fsm == ST_WAIT && startup_done_i && !over_temp_i && r_reg.ctrl[`RSDC_CTRL_EN]
    |=> !repeat_en_o ##0 drv_upper_o)
    else $error("repetition not disabled");
  rep_on_a: assert property (@(posedge clk_i) disable iff (rst_i || !ce_i)
    drv_upper_o && !ontime_cmp_i |=> repeat_en_o && !drv_upper_o)
    else $error("comparator trip ignored");
  tmax_gate_a: assert property (@(posedge clk_i) disable iff (rst_i || !ce_i)
    $rose(r_reg.tmax_flt) |-> $past(ss_cnt) == $past(r_reg.maxon[11:0]))
    else $error("max on-time fault below limit");
  wb_ack_a: assert property (@(posedge clk_i) disable iff (rst_i || !ce_i)
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
    else $error("bus answer not one cycle");
endmodule
`default_nettype wire

// file: rsdc_tank.sv
`timescale 1ns/100ps
`default_nettype none
// half-bridge switches and resonant tank seen from the drivers
module rsdc_tank (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic up_i,
  input  wire logic lo_i,
  input  wire logic stuck_i,
  output logic      up2lo_o,
  output logic      lo2up_o,
  output logic      floor_o
);
  logic [3:0] cnt;
  logic       was_up;
  // idle cycles since a switch let go, saturating
  always_ff @(posedge clk_i) begin
    if (rst_i || up_i || lo_i)
      cnt <= 4'h0;
    else if (cnt != 4'hf)
      cnt <= cnt + 4'h1;
    if (rst_i)
      was_up <= 1'b0;
    else if (up_i || lo_i)
      was_up <= up_i;
  end
  // swing ends 3 cycles after turn-off, never when stuck
  assign up2lo_o = was_up && cnt >= 4'h3 && !stuck_i;
  assign lo2up_o = !was_up && cnt >= 4'h3 && !stuck_i;
  // node sits at the floor once idle a while
  assign floor_o = cnt >= 4'h4;
endmodule
`default_nettype wire

// file: testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import rsdc_pkg::*;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc = 1'b0, we = 1'b0, sd = 1'b0, skp = 1'b0, ot = 1'b0, tl = 1'b0, stk = 1'b0;
  logic        cmp = 1'b1, ll = 1'b0, qt = 1'b0;
  logic [3:0]  sel = 4'h0;
  logic [7:0]  adr = 8'h00;
  logic [31:0] wd = 32'h0, dato, rd;
  rsdc_on_t    son = '0, dac;
  logic        ack, up, lo, dis, rep, flt, u2l, l2u, flr;
  int          err_count = 0, checked = 0, n, g, l;
  // clock, design and far side
  initial forever #4 clk_i = ~clk_i;
  rsdc_top #(.QUIET_CYCLES(16'h0008), .AREC_CYCLES(20)) dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1),
    .wb_adr_i(adr), .wb_dat_i(wd), .wb_sel_i(sel), .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(cyc),
    .wb_dat_o(dato), .wb_ack_o(ack), .startup_done_i(sd), .startup_ontime_i(son), .ontime_cmp_i(cmp),
    .fb_below_skip_i(skp), .light_load_i(ll), .fb_below_quiet_i(qt), .trans_end_up2lo_i(u2l),
    .trans_end_lo2up_i(l2u), .bridge_floor_i(flr), .over_temp_i(ot), .temp_low_i(tl), .drv_upper_o(up),
    .drv_lower_o(lo), .bridge_discharge_o(dis), .dac_o(dac), .repeat_en_o(rep), .fault_latched_o(flt));
  rsdc_tank tank (.clk_i(clk_i), .rst_i(rst_i), .up_i(up), .lo_i(lo), .stuck_i(stk),
    .up2lo_o(u2l), .lo2up_o(l2u), .floor_o(flr));
  task automatic finish_test;
    if (err_count == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic hang;
    err_count++;
    finish_test();
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    checked++;
    if (s !== e) begin
      err_count++;
      $display("FAIL %s exp %h got %h", nm, e, s);
    end
  endtask
  // one classic cycle, held until the edge that samples ack
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    we  <= w;
    adr <= a;
    wd  <= d;
    sel <= 4'hf;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 99);
    if (ack !== 1'b1)
      hang();
    rd = dato;
    cyc <= 1'b0;
    we  <= 1'b0;
  endtask
  function automatic logic pick(input int s);
    return (s == 0) ? up : (s == 1) ? lo : dis;
  endfunction
  // low cycles before a pulse into g, its length into l
  task automatic pulse(input int s);
    g = 0;
    l = 0;
    while (pick(s) !== 1'b1 && g < 3000) begin
      @(negedge clk_i);
      g++;
    end
    while (pick(s) === 1'b1 && l < 3000) begin
      @(negedge clk_i);
      l++;
    end
    if (g >= 3000 || l >= 3000)
      hang();
  endtask
  task automatic start(input rsdc_on_t v);
    @(posedge clk_i);
    son <= v;
    sd  <= 1'b1;
    @(posedge clk_i);
    sd  <= 1'b0;
    @(negedge clk_i);
  endtask
  // main sequence
  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, 8'h04, 32'h0);
    chk("sscfg", 32'h0000_0110, rd);
    wb(1'b0, 8'h08, 32'h0);
    chk("timcfg", 32'h09c4_047d, rd);
    wb(1'b0, 8'h3c, 32'h0);
    chk("unmapped", 32'h0, rd);
    wb(1'b1, 8'h10, 32'h28);
    wb(1'b1, 8'h08, 32'h0010_010a);
    wb(1'b1, 8'h04, 32'h0000_0208);
    wb(1'b1, 8'h00, 32'h9);
    pulse(2);
    wb(1'b0, 8'h14, 32'h0);
    chk("state", 32'h2, rd & 32'hf);
    start(12'h014);
    pulse(0);
    chk("upper", 32'h14, l);
    chk("dac", 32'h14, dac);
    chk("repeat", 32'h0, rep);
    pulse(1);
    chk("gap", 32'hb, g);
    chk("lower", 32'h14, l);
    repeat (3) pulse(1);
    chk("dac", 32'h24, dac);
    @(posedge clk_i);
    skp <= 1'b1;
    repeat (3) @(negedge clk_i);
    chk("dac sat", 32'h28, dac);
    @(posedge clk_i);
    skp <= 1'b0;
    cmp <= 1'b0;
    pulse(0);
    chk("cmp upper", 32'h1, l);
    chk("repeat on", 32'h1, rep);
    @(posedge clk_i);
    cmp <= 1'b1;
    ll  <= 1'b1;
    pulse(1);
    pulse(0);
    chk("off-time", 32'h1b, g);
    @(posedge clk_i);
    ll <= 1'b0;
    qt <= 1'b1;
    pulse(1);
    repeat (40) @(negedge clk_i);
    chk("skip hold", 32'h0, up);
    @(posedge clk_i);
    qt <= 1'b0;
    pulse(0);
    chk("skip exit", 32'h2, g);
    @(posedge clk_i);
    ot  <= 1'b1;
    @(posedge clk_i);
    @(negedge clk_i);
    chk("drivers", 32'h0, {up, lo});
    wb(1'b0, 8'h14, 32'h0);
    chk("therm", 32'hb9, rd & 32'hbf);
    wb(1'b1, 8'h00, 32'h1);
    ot <= 1'b0;
    tl <= 1'b1;
    pulse(2);
    @(posedge clk_i);
    tl <= 1'b0;
    start(12'h014);
    pulse(0);
    pulse(1);
    chk("sense gap", 32'h1, g < 11);
    @(posedge clk_i);
    stk <= 1'b1;
    pulse(0);
    pulse(1);
    chk("forced gap", 32'hb, g);
    chk("no fault", 32'h0, flt);
    wb(1'b1, 8'h00, 32'h3);
    n = 0;
    while (flt !== 1'b1 && n < 3000) begin
      @(negedge clk_i);
      n++;
    end
    chk("latched", 32'h1, flt);
    chk("stopped", 32'h0, {up, lo});
    wb(1'b0, 8'h14, 32'h0);
    chk("gap fault", 32'h4a, rd & 32'h4f);
    finish_test();
  end
endmodule
`default_nettype wire
